//--- hw/sxr_pkg.sv
`default_nettype none

package sxr_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int           REG_W         = 8;
   localparam int           ADDR_W        = 12;
   localparam int           DATA_W        = 32;
   localparam int           SYNC_STAGES   = 2;
   localparam int           CTRL_W        = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0]  OFS_CTRL      = 12'h000;
   localparam logic [11:0]  OFS_STATUS    = 12'h004;
   localparam logic [11:0]  OFS_PINS      = 12'h008;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int           CTRL_GO_N     = 0;
   localparam int           CTRL_SERIAL   = 1;
   localparam int           CTRL_SIGN_N   = 2;
   localparam int           CTRL_SEL      = 3;
   localparam int           CTRL_DRV_N    = 4;
   localparam logic [4:0]   CTRL_RST      = 5'h17;

   // ----------------------------------------------------------------
   // Status fields
   // ----------------------------------------------------------------
   localparam int           STAT_VAL_LSB  = 0;
   localparam int           STAT_OE       = 8;
   localparam int           STAT_FULL     = 9;
   localparam int           STAT_MODE_LSB = 10;

   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_SHIFT_IN,
      MODE_SIGN_EXT,
      MODE_LOAD
   } sxr_mode_t;

endpackage : sxr_pkg

`default_nettype wire

//--- hw/sxr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sxr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // ----------------------------------------------------------------
   // Two stages; first stage feeds only the second
   // ----------------------------------------------------------------
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : sxr_sync

`default_nettype wire

//--- hw/sxr_buf2.sv
`timescale 1ns/1ps
`default_nettype none

module sxr_buf2 #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);

   // ----------------------------------------------------------------
   // Head drives the outputs, tail catches the word during a stall
   // ----------------------------------------------------------------
   logic [W-1:0] tail_q;
   logic         tail_v_q;
   logic [W-1:0] head_d;
   logic [W-1:0] tail_d;
   logic         head_v_d;
   logic         tail_v_d;
   wire          push = in_valid & in_ready;
   wire          pop  = out_valid & out_ready;

   always_comb begin
      head_d   = out_data;
      head_v_d = out_valid;
      tail_d   = tail_q;
      tail_v_d = tail_v_q;
      if (pop) begin
         head_d   = tail_q;
         head_v_d = tail_v_q;
         tail_v_d = 1'b0;
      end
      if (push) begin
         if (head_v_d) begin
            tail_d   = in_data;
            tail_v_d = 1'b1;
         end else begin
            head_d   = in_data;
            head_v_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_data  <= '0;
         out_valid <= 1'b0;
         tail_q    <= '0;
         tail_v_q  <= 1'b0;
         in_ready  <= 1'b1;
      end else begin
         out_data  <= head_d;
         out_valid <= head_v_d;
         tail_q    <= tail_d;
         tail_v_q  <= tail_v_d;
         in_ready  <= ~tail_v_d;
      end
   end

endmodule : sxr_buf2

`default_nettype wire

//--- hw/sxr_top.sv
`timescale 1ns/1ps
`default_nettype none

module sxr_top #(
   parameter int REG_W = sxr_pkg::REG_W
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic [sxr_pkg::ADDR_W-1:0] paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [sxr_pkg::DATA_W-1:0] pwdata,
   output logic      [sxr_pkg::DATA_W-1:0] prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      clear_all_n,
   input  wire logic                      entry_a,
   input  wire logic                      entry_b,
   input  wire logic [REG_W-1:0]          bus_pins_i,
   output logic      [REG_W-1:0]          bus_pins_o,
   output logic                           bus_pins_oe,
   output logic                           low_bit_out,
   output logic      [REG_W-1:0]          word_data,
   output logic                           word_valid,
   input  wire logic                      word_ready
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [REG_W-1:0]           shift_q;
   logic [REG_W-1:0]           shift_d;
   logic [sxr_pkg::CTRL_W-1:0] ctrl_q;
   logic [sxr_pkg::CTRL_W-1:0] ctrl_d;
   logic                       oe_q;
   logic                       oe_d;
   sxr_pkg::sxr_mode_t         mode_q;
   sxr_pkg::sxr_mode_t         mode_d;
   logic                       clr_rst_n;
   logic [REG_W+1:0]           pins_sync;
   logic [REG_W-1:0]           pins_s;
   logic                       entry_a_s;
   logic                       entry_b_s;
   logic                       buf_in_ready;
   logic [sxr_pkg::DATA_W-1:0] rdata_d;
   logic                       err_d;

   // ----------------------------------------------------------------
   // Clear: asserts at once, releases on a clock edge
   // ----------------------------------------------------------------
   // Synchronised release avoids a recovery hazard against pclk
   wire clr_async_n = presetn & clear_all_n;

   sxr_sync #(
      .W     (1)
   ) u_clr_sync (
      .clk   (pclk),
      .rst_n (clr_async_n),
      .d     (1'b1),
      .q     (clr_rst_n)
   );

   // ----------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------
   sxr_sync #(
      .W     (REG_W + 2)
   ) u_pin_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({entry_b, entry_a, bus_pins_i}),
      .q     (pins_sync)
   );

   assign pins_s    = pins_sync[REG_W-1:0];
   assign entry_a_s = pins_sync[REG_W];
   assign entry_b_s = pins_sync[REG_W+1];

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   wire go_n_c    = ctrl_q[sxr_pkg::CTRL_GO_N];
   wire serial_c  = ctrl_q[sxr_pkg::CTRL_SERIAL];
   wire sign_n_c  = ctrl_q[sxr_pkg::CTRL_SIGN_N];
   wire sel_c     = ctrl_q[sxr_pkg::CTRL_SEL];
   wire drv_n_c   = ctrl_q[sxr_pkg::CTRL_DRV_N];

   // ----------------------------------------------------------------
   // Shift datapath
   // ----------------------------------------------------------------
   // A full snapshot buffer stalls the step so no word is lost
   wire go_req    = ~go_n_c & clr_rst_n;
   wire go        = go_req & buf_in_ready;
   wire entry_bit = sel_c ? entry_b_s : entry_a_s;
   wire top_in    = sign_n_c ? entry_bit : shift_q[REG_W-1];
   wire [REG_W-1:0] shifted = {top_in, shift_q[REG_W-1:1]};
   wire [REG_W-1:0] step    = serial_c ? shifted : pins_s;

   assign shift_d = go ? step : shift_q;

   // Drive-enable does not gate the datapath at all
   always_ff @(posedge pclk or negedge clr_rst_n) begin
      if (!clr_rst_n) begin
         shift_q <= '0;
      end else begin
         shift_q <= shift_d;
      end
   end

   assign mode_d = !go        ? sxr_pkg::MODE_HOLD :
                   !serial_c  ? sxr_pkg::MODE_LOAD :
                   sign_n_c   ? sxr_pkg::MODE_SHIFT_IN :
                                sxr_pkg::MODE_SIGN_EXT;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= sxr_pkg::MODE_HOLD;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------
   // Bus pin drivers
   // ----------------------------------------------------------------
   // Taken from the next control value so the enable moves with it
   assign oe_d = ~ctrl_d[sxr_pkg::CTRL_DRV_N] & ctrl_d[sxr_pkg::CTRL_SERIAL];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   assign bus_pins_o  = shift_q;
   assign bus_pins_oe = oe_q;
   assign low_bit_out = shift_q[0];

   // ----------------------------------------------------------------
   // Snapshot buffer
   // ----------------------------------------------------------------
   sxr_buf2 #(
      .W         (REG_W)
   ) u_buf (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (go_req),
      .in_ready  (buf_in_ready),
      .in_data   (step),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait-free access cycle: pready rises at the setup edge
   wire setup     = psel & ~penable;
   wire access    = psel & penable & pready;
   wire hit_ctrl  = (paddr == sxr_pkg::OFS_CTRL);
   wire hit_stat  = (paddr == sxr_pkg::OFS_STATUS);
   wire hit_pins  = (paddr == sxr_pkg::OFS_PINS);
   wire hit_any   = hit_ctrl | hit_stat | hit_pins;
   wire wr_ctrl   = access & pwrite & hit_ctrl;

   assign ctrl_d  = wr_ctrl ? pwdata[sxr_pkg::CTRL_W-1:0] : ctrl_q;

   wire [sxr_pkg::DATA_W-1:0] stat_word = {
      {(sxr_pkg::DATA_W - 12){1'b0}},
      mode_q,
      ~buf_in_ready,
      oe_q,
      shift_q
   };

   always_comb begin
      rdata_d = '0;
      err_d   = 1'b0;
      if (!hit_any) begin
         err_d = 1'b1;
      end else if (pwrite) begin
         rdata_d = '0;
      end else if (hit_ctrl) begin
         rdata_d = {{(sxr_pkg::DATA_W - sxr_pkg::CTRL_W){1'b0}}, ctrl_q};
      end else if (hit_stat) begin
         rdata_d = stat_word;
      end else begin
         rdata_d = {{(sxr_pkg::DATA_W - REG_W){1'b0}}, pins_s};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= sxr_pkg::CTRL_RST;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         ctrl_q  <= ctrl_d;
         pready  <= setup;
         pslverr <= setup & err_d;
         prdata  <= setup ? rdata_d : '0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_shift_step;
      go && serial_c;
   endsequence

   sequence s_load_step;
      go && !serial_c;
   endsequence

   a_hold_when_off: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      (go_n_c || !buf_in_ready) |=> (shift_q == $past(shift_q)))
      else $error("register changed while held");

   a_shift_moves_down: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      s_shift_step |=> (shift_q[REG_W-2:0] == $past(shift_q[REG_W-1:1])))
      else $error("shift did not move bits down");

   a_sign_top_kept: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      (s_shift_step ##0 !sign_n_c) |=> (shift_q[REG_W-1] == $past(shift_q[REG_W-1])))
      else $error("top bit not kept in sign copy");

   a_entry_top_bit: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      (s_shift_step ##0 sign_n_c) |=>
         (shift_q[REG_W-1] == ($past(sel_c) ? $past(entry_b_s) : $past(entry_a_s))))
      else $error("wrong serial entry into top bit");

   a_load_from_pins: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      s_load_step |=> (shift_q == $past(pins_s)))
      else $error("parallel load mismatch");

   a_drivers_off: assert property (@(posedge pclk) disable iff (!presetn)
      (drv_n_c || !serial_c) |-> !bus_pins_oe)
      else $error("bus pins driven while disabled");

   a_drivers_on: assert property (@(posedge pclk) disable iff (!presetn)
      (!drv_n_c && serial_c) |-> (bus_pins_oe && bus_pins_o == shift_q))
      else $error("bus pins not driven with register");

   a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(clr_rst_n) |-> (shift_q == '0 && !low_bit_out))
      else $error("register not clear after clear");

   a_float_still_steps: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      (s_shift_step ##0 drv_n_c) |=> (shift_q[REG_W-2:0] == $past(shift_q[REG_W-1:1])))
      else $error("shift stopped while pins floated");

   a_word_kept: assert property (@(posedge pclk) disable iff (!presetn)
      (word_valid && !word_ready) |=> (word_valid && $stable(word_data)))
      else $error("buffered word lost under stall");

   sequence s_apb_setup;
      psel && !penable;
   endsequence

   sequence s_clear_on;
      !clear_all_n;
   endsequence

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_setup |=> pready)
      else $error("no answer after setup cycle");

   a_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (s_apb_setup ##0 !hit_any) |=> (pslverr && prdata == '0))
      else $error("unmapped access without error");

   a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      (s_apb_setup ##0 hit_any) |=> !pslverr)
      else $error("error on a mapped register");

   a_answer_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == '0 && !pslverr))
      else $error("read data outside the answer cycle");

   a_ctrl_written: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> (ctrl_q == $past(pwdata[sxr_pkg::CTRL_W-1:0])))
      else $error("control write did not land");

   a_ctrl_kept: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_ctrl |=> $stable(ctrl_q))
      else $error("control changed without a write");

   a_oe_written: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> (bus_pins_oe ==
         (!$past(pwdata[sxr_pkg::CTRL_DRV_N]) && $past(pwdata[sxr_pkg::CTRL_SERIAL]))))
      else $error("drive enable does not follow the control write");

   a_clear_holds: assert property (@(posedge pclk) disable iff (!presetn)
      s_clear_on |-> (shift_q == '0 && !low_bit_out))
      else $error("register not held clear");

   a_clear_pins_low: assert property (@(posedge pclk) disable iff (!presetn)
      (s_clear_on ##0 bus_pins_oe) |-> (bus_pins_o == '0))
      else $error("driven bus pins not low during clear");

   a_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !go |=> (mode_q == sxr_pkg::MODE_HOLD))
      else $error("step reported while held");

   a_mode_step: assert property (@(posedge pclk) disable iff (!presetn)
      go |=> (mode_q != sxr_pkg::MODE_HOLD))
      else $error("enabled edge reported as hold");

   a_mode_load: assert property (@(posedge pclk) disable iff (!presetn)
      s_load_step |=> (mode_q == sxr_pkg::MODE_LOAD))
      else $error("load not reported as load");

   a_load_off_pins: assert property (@(posedge pclk) disable iff (!presetn)
      s_load_step |-> !bus_pins_oe)
      else $error("device drives pins during a load");

   a_word_pushed: assert property (@(posedge pclk) disable iff (!presetn)
      go |=> word_valid)
      else $error("step left no snapshot word");

   a_float_holds: assert property (@(posedge pclk) disable iff (!clr_rst_n)
      (go_n_c && drv_n_c) |=> $stable(shift_q))
      else $error("register moved while held and floated");

endmodule : sxr_top

`default_nettype wire

//--- test/sxr_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module sxr_far_end (
   input  wire logic       pclk,
   input  wire logic       oe,
   input  wire logic [7:0] dev_val,
   input  wire logic       req,
   input  wire logic [7:0] val,
   output logic      [7:0] pins
);
   // ----------------------------------------------------------------
   // Shared pins
   // ----------------------------------------------------------------
   logic [7:0] pat_q = 8'h5A;

   // Released wire toggles, so a stale value never passes
   always_ff @(posedge pclk) begin
      pat_q <= ~pat_q;
   end

   // Drives only while the device is off the pins
   assign pins = oe ? dev_val : (req ? val : pat_q);
endmodule : sxr_far_end

`default_nettype wire

//--- test/test_sign_extend_shift_register.sv
`timescale 1ns/1ps
`default_nettype none

module test_sign_extend_shift_register;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        clear_all_n, entry_a, entry_b, oe, low_bit_out, word_valid, word_ready;
   logic        far_req, stall, force_rdy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  pins, dev_val, word_data, far_val, last;
   logic [4:0]  cur;
   logic [4:0]  ops [5] = '{5'h00, 5'h06, 5'h0A, 5'h1E, 5'h12};
   int          num_errors, n_checks, seed;

   sxr_top #(.REG_W(8)) sxr_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clear_all_n(clear_all_n), .entry_a(entry_a), .entry_b(entry_b),
      .bus_pins_i(pins), .bus_pins_o(dev_val), .bus_pins_oe(oe), .low_bit_out(low_bit_out),
      .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready));
   sxr_far_end sxr_far_end_i (.pclk(pclk), .oe(oe), .dev_val(dev_val), .req(far_req),
      .val(far_val), .pins(pins));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         chk("apb wait", 1'b0, 1'b1);
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Next register value from the previous one
   function automatic logic [7:0] nxt(input logic [7:0] p);
      if (!cur[sxr_pkg::CTRL_SERIAL]) return far_val;
      if (!cur[sxr_pkg::CTRL_SIGN_N]) return {p[7], p[7:1]};
      return {cur[sxr_pkg::CTRL_SEL] ? entry_b : entry_a, p[7:1]};
   endfunction : nxt

   // Random back-pressure, except when forced
   always @(posedge pclk) begin
      word_ready <= stall ? 1'b0 : (force_rdy | ($random(seed) % 3 != 0));
      // A clear empties the register model too
      if (presetn !== 1'b1 || clear_all_n !== 1'b1) begin
         last = 8'h00;
      end else if (word_valid === 1'b1 && word_ready === 1'b1) begin
         chk("word", word_data, nxt(last));
         last = nxt(last);
      end
   end

   task automatic drain;
      int i;
      force_rdy <= 1'b1;
      repeat (3) @(posedge pclk);
      for (i = 0; i < 20 && word_valid !== 1'b0; i++) @(posedge pclk);
      if (i == 20) begin
         chk("drain", 1'b0, 1'b1);
         stop_test();
      end
   endtask : drain

   // ----------------------------------------------------------------
   // One operation: hold, run, optional stall, stop, compare
   // ----------------------------------------------------------------
   task automatic run_op(input logic [4:0] c, input int n, input logic hold_up);
      logic [1:0] md;
      md = !c[1] ? 2'd3 : (c[2] ? 2'd1 : 2'd2);
      entry_a <= 1'($random(seed));
      entry_b <= 1'($random(seed));
      far_req <= !c[1];
      far_val <= 8'($random(seed)) | 8'h01;
      cur = c;
      apb(sxr_pkg::OFS_CTRL, 1'b1, {27'h0, c | 5'h01});
      repeat (3) @(posedge pclk);
      apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("hold reg", rd[7:0], last);
      chk("hold mode", rd[11:10], 2'd0);
      if (!c[1]) begin
         apb(sxr_pkg::OFS_PINS, 1'b0, 32'h0);
         chk("pins", rd[7:0], far_val);
      end
      apb(sxr_pkg::OFS_CTRL, 1'b1, {27'h0, c});
      apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("mode", rd[11:10], md);
      chk("oe bit", rd[8], !c[4] && c[1]);
      chk("oe pin", oe, !c[4] && c[1]);
      force_rdy <= 1'b0;
      stall <= hold_up;
      repeat (n) @(posedge pclk);
      if (hold_up) begin
         apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
         chk("full", rd[9], 1'b1);
         chk("stall mode", rd[11:10], 2'd0);
         stall <= 1'b0;
      end
      apb(sxr_pkg::OFS_CTRL, 1'b1, {27'h0, c | 5'h01});
      drain();
      apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("reg", rd[7:0], last);
      chk("serial out", low_bit_out, last[0]);
      if (oe === 1'b1) chk("bus out", dev_val, last);
   endtask : run_op

   initial begin
      int k;
      seed = 57007;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {clear_all_n, entry_a, entry_b, far_req, far_val} = {1'b1, 11'h0};
      {stall, force_rdy, cur, num_errors, n_checks} = {2'b01, 5'h17, 64'h0};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(sxr_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("ctrl reset", rd[4:0], sxr_pkg::CTRL_RST);
      apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("status reset", rd[11:0], 12'h000);
      chk("oe reset", oe, 1'b0);
      apb(12'h00C, 1'b0, 32'h0);
      chk("unmapped err", er, 1'b1);
      chk("unmapped data", rd, 32'h0);
      apb(12'h010, 1'b1, 32'h0);
      apb(sxr_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("ctrl kept", rd[4:0], sxr_pkg::CTRL_RST);
      for (k = 0; k < 5; k++) run_op(ops[k], 12, k == 3);
      run_op(5'h00, 4, 1'b0);
      // Clear with drivers on: pins and serial output must drop at once
      far_req <= 1'b0;
      apb(sxr_pkg::OFS_CTRL, 1'b1, 32'h3);
      @(posedge pclk);
      clear_all_n <= 1'b0;
      #1;
      chk("clr serial", low_bit_out, 1'b0);
      chk("clr bus", dev_val, 8'h00);
      apb(sxr_pkg::OFS_STATUS, 1'b0, 32'h0);
      chk("clr reg", rd[8:0], 9'h100);
      clear_all_n <= 1'b1;
      for (k = 0; k < 8; k++) run_op({4'($random(seed)), 1'b0}, 3 + $unsigned($random(seed)) % 10, 1'b0);
      stop_test();
   end
endmodule : test_sign_extend_shift_register

`default_nettype wire
